// [design/wdit_defs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef WDIT_DEFS_SVH
`define WDIT_DEFS_SVH

`define WDIT_ADDR_W 8
`define WDIT_CTRL_OFS 8'hC9
`define WDIT_IRQ_STAT_OFS 8'hD0
`define WDIT_IRQ_MASK_OFS 8'hD1
`define WDIT_MODE_STAT_OFS 8'hD2

`define WDIT_CLR_MSB 7
`define WDIT_CLR_LSB 4
`define WDIT_EN_BIT 3
`define WDIT_MODE_BIT 2
`define WDIT_INT_MSB 1
`define WDIT_INT_LSB 0

`define WDIT_CTRL_RST 8'h00
`define WDIT_KEY_FIRST 4'hA
`define WDIT_KEY_SECOND 4'h5

`define WDIT_IRQ_TIMER_BIT 0
`define WDIT_IRQ_RESET_BIT 1

`define WDIT_CNT_W 15
`define WDIT_IVL_00 16'h8000
`define WDIT_IVL_01 16'h2000
`define WDIT_IVL_10 16'h0200
`define WDIT_IVL_11 16'h0040

`define WDIT_CLK_HZ 50000000
`define WDIT_WDCLK_HZ 32768
`define WDIT_RESET_PULSE 8'h04

`endif

// [design/wdit_pkg.sv]
// Types shared by the watchdog and interval timer
package wdit_pkg;

  typedef enum logic [3:0] {
    WDIT_PM_ACTIVE = 4'h1,
    WDIT_PM_IDLE = 4'h2,
    WDIT_PM_LIGHT = 4'h4,
    WDIT_PM_DEEP = 4'h8
  } wdit_pm_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdit_bus_s;

  typedef enum logic [1:0] {
    WDIT_KEY_IDLE = 2'h1,
    WDIT_KEY_ARMED = 2'h2
  } wdit_key_e;

endpackage : wdit_pkg

// [design/wdit_top.sv]
// Watchdog and interval timer with register port and power-mode handling
`timescale 1ns/1ps
`include "wdit_defs.svh"

module wdit_top #(
  parameter int unsigned CLK_HZ = `WDIT_CLK_HZ,
  parameter int unsigned WDCLK_HZ = `WDIT_WDCLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire wdit_pkg::wdit_bus_s bus,
  output logic [7:0] rdata,
  // Power mode and interrupt enable
  input wire wdit_pkg::wdit_pm_e power_mode,
  input wire logic timer_interval_irq_enable,
  // Events
  output logic timer_interval_flag,
  output logic system_reset_req,
  output logic irq
);
  import wdit_pkg::*;

  localparam int unsigned TICK_DIV = CLK_HZ / WDCLK_HZ;
  localparam int unsigned HALF_DIV = TICK_DIV / 2;
  localparam logic [`WDIT_CNT_W-1:0] CNT_ONE =
    {{(`WDIT_CNT_W-1){1'b0}}, 1'b1};

  // The key window is half a tick, so a tick needs a few clocks to split
  if (TICK_DIV < 4 || TICK_DIV > 65536) begin : g_div_chk
    $error("Watchdog clock ratio out of range");
  end

  // ==========================================================
  // Watchdog clock divider
  // Key window counts system clocks down from HALF_DIV, so it is half a period rounded down.
  logic [15:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    div_nxt = div_r + 16'h0001;
    tick_nxt = 1'b0;
    if (div_r >= 16'(TICK_DIV - 1)) begin
      div_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ==========================================================
  // Control register, key sequence and counter
  logic en_r, en_nxt;
  logic mode_r, mode_nxt;
  logic [1:0] ivl_r, ivl_nxt;
  logic [3:0] clr_r, clr_nxt;
  wdit_key_e key_r, key_nxt;
  logic [15:0] win_r, win_nxt;
  logic clear_pend_r, clear_pend_nxt;
  logic [`WDIT_CNT_W-1:0] cnt_r, cnt_nxt;
  logic expired_r, expired_nxt;
  logic [15:0] limit;
  logic ctrl_wr, hit, deep, light;
  logic [3:0] key_in;

  assign ctrl_wr = bus.wr && bus.addr == `WDIT_CTRL_OFS;
  assign key_in = bus.wdata[`WDIT_CLR_MSB:`WDIT_CLR_LSB];
  assign deep = power_mode == WDIT_PM_DEEP;
  assign light = power_mode == WDIT_PM_LIGHT;

  always_comb begin
    unique case (ivl_r)
      2'b00: limit = `WDIT_IVL_00;
      2'b01: limit = `WDIT_IVL_01;
      2'b10: limit = `WDIT_IVL_10;
      2'b11: limit = `WDIT_IVL_11;
    endcase
  end

  assign hit = {1'b0, cnt_r} + 16'h0001 >= limit;

  always_comb begin
    en_nxt = en_r;
    mode_nxt = mode_r;
    ivl_nxt = ivl_r;
    clr_nxt = clr_r;
    key_nxt = key_r;
    win_nxt = win_r;
    // A tick consumes a pending clear; a key landing on it re-arms it
    clear_pend_nxt = clear_pend_r && !tick_r;
    cnt_nxt = cnt_r;
    expired_nxt = 1'b0;
    if (key_r == WDIT_KEY_ARMED) begin
      if (win_r == 16'h0000) begin
        key_nxt = WDIT_KEY_IDLE;
      end else begin
        win_nxt = win_r - 16'h0001;
      end
    end
    if (ctrl_wr) begin
      ivl_nxt = bus.wdata[`WDIT_INT_MSB:`WDIT_INT_LSB];
      if (!(en_r && !mode_r)) begin
        mode_nxt = bus.wdata[`WDIT_MODE_BIT];
      end
      if (bus.wdata[`WDIT_EN_BIT]) begin
        en_nxt = 1'b1;
        if (!en_r) begin
          cnt_nxt = '0;
        end
      end else if (mode_r || !en_r) begin
        en_nxt = 1'b0;
      end
      if (en_r) begin
        clr_nxt = key_in;
        if (key_in == `WDIT_KEY_FIRST) begin
          key_nxt = WDIT_KEY_ARMED;
          win_nxt = 16'(HALF_DIV);
        end else if (key_in == `WDIT_KEY_SECOND &&
                     key_r == WDIT_KEY_ARMED && win_r != 16'h0000) begin
          key_nxt = WDIT_KEY_IDLE;
          clear_pend_nxt = 1'b1;
        end else if (mode_r && key_in[0]) begin
          clear_pend_nxt = 1'b1;
        end else begin
          key_nxt = WDIT_KEY_IDLE;
        end
      end
    end
    if (deep) begin
      cnt_nxt = '0;
      clear_pend_nxt = 1'b0;
    end else if (tick_r) begin
      if (clear_pend_r) begin
        cnt_nxt = '0;
      end else if (en_r) begin
        if (hit) begin
          cnt_nxt = '0;
          expired_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_r <= 1'b0;
      mode_r <= 1'b0;
      ivl_r <= 2'b00;
      clr_r <= 4'h0;
      key_r <= WDIT_KEY_IDLE;
      win_r <= 16'h0000;
      clear_pend_r <= 1'b0;
      cnt_r <= '0;
      expired_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      mode_r <= mode_nxt;
      ivl_r <= ivl_nxt;
      clr_r <= clr_nxt;
      key_r <= key_nxt;
      win_r <= win_nxt;
      clear_pend_r <= clear_pend_nxt;
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

  // ==========================================================
  // Timeout handling, reset and interrupt
  // A light-sleep timeout is held until wake so the reset still happens.
  logic wd_pend_r, wd_pend_nxt;
  logic [7:0] rst_cnt_r, rst_cnt_nxt;
  logic flag_r, flag_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  logic fire;

  assign fire = wd_pend_r && !light && !deep;

  always_comb begin
    wd_pend_nxt = wd_pend_r;
    rst_cnt_nxt = rst_cnt_r;
    flag_nxt = flag_r;
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `WDIT_CTRL_OFS: rdata_nxt = {clr_r, en_r, mode_r, ivl_r};
        `WDIT_IRQ_STAT_OFS: begin
          rdata_nxt = {6'h00, stat_r};
          stat_nxt = 2'b00;
        end
        `WDIT_IRQ_MASK_OFS: rdata_nxt = {6'h00, mask_r};
        `WDIT_MODE_STAT_OFS: rdata_nxt = {7'h00, flag_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (bus.wr && bus.addr == `WDIT_IRQ_MASK_OFS) begin
      mask_nxt = bus.wdata[1:0];
    end
    if (bus.wr && bus.addr == `WDIT_MODE_STAT_OFS && bus.wdata[0]) begin
      flag_nxt = 1'b0;
    end
    if (expired_r && !mode_r) begin
      wd_pend_nxt = 1'b1;
    end
    if (expired_r && mode_r) begin
      flag_nxt = 1'b1;
      stat_nxt[`WDIT_IRQ_TIMER_BIT] = 1'b1;
    end
    if (fire) begin
      wd_pend_nxt = 1'b0;
      rst_cnt_nxt = `WDIT_RESET_PULSE;
      stat_nxt[`WDIT_IRQ_RESET_BIT] = 1'b1;
    end else if (rst_cnt_r != 8'h00) begin
      rst_cnt_nxt = rst_cnt_r - 8'h01;
    end
    irq_nxt = |(stat_nxt & mask_nxt) ||
              (flag_nxt && timer_interval_irq_enable);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_pend_r <= 1'b0;
      rst_cnt_r <= 8'h00;
      flag_r <= 1'b0;
      stat_r <= 2'b00;
      mask_r <= 2'b00;
      rdata <= 8'h00;
      irq <= 1'b0;
      system_reset_req <= 1'b0;
      timer_interval_flag <= 1'b0;
    end else begin
      wd_pend_r <= wd_pend_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      flag_r <= flag_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata <= rdata_nxt;
      irq <= irq_nxt;
      system_reset_req <= rst_cnt_nxt != 8'h00;
      timer_interval_flag <= flag_nxt;
    end
  end

  // ==========================================================
  // Checks
  a_deep_clears_cnt: assert property (@(posedge clk) disable iff (sys_rst)
    deep |=> cnt_r == '0) else $error("Counter not cleared in deep sleep");
  a_wd_no_disable: assert property (@(posedge clk) disable iff (sys_rst)
    en_r && !mode_r |=> en_r) else $error("Watchdog got disabled");
  a_timer_stop_en: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && mode_r && !bus.wdata[`WDIT_EN_BIT] |=> !en_r)
    else $error("Timer did not stop");
  a_key_clear_cnt: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && en_r && key_r == WDIT_KEY_ARMED && win_r != 16'h0000 &&
    key_in == `WDIT_KEY_SECOND && !deep |=> clear_pend_r)
    else $error("Key sequence not honoured");
  a_no_clr_disabled: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_wr && !en_r |=> clr_r == $past(clr_r))
    else $error("Clear field changed while disabled");
  a_light_no_reset: assert property (@(posedge clk) disable iff (sys_rst)
    light && rst_cnt_r == 8'h00 |=> !system_reset_req)
    else $error("Reset issued in light sleep");
  a_wd_timeout_rst: assert property (@(posedge clk) disable iff (sys_rst)
    expired_r && !mode_r && power_mode == WDIT_PM_ACTIVE
    ##1 power_mode == WDIT_PM_ACTIVE |=> system_reset_req)
    else $error("Watchdog timeout gave no reset");
  a_timer_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
    expired_r && mode_r |=> timer_interval_flag && !system_reset_req ||
    $past(rst_cnt_r) != 8'h00)
    else $error("Timer timeout did not set flag");
  a_mode_frozen: assert property (@(posedge clk) disable iff (sys_rst)
    en_r && !mode_r |=> !mode_r) else $error("Mode changed");

endmodule : wdit_top

// [testbench/wdit_top_test.sv]
// Self-checking testbench for the watchdog and interval timer
`timescale 1ns/1ps
`include "wdit_defs.svh"

module wdit_top_test;
  import wdit_pkg::*;

  // ==========================================================
  // Signals and design instance
  localparam logic [7:0] CT = `WDIT_CTRL_OFS;
  localparam logic [7:0] ST = `WDIT_IRQ_STAT_OFS;
  localparam logic [7:0] MK = `WDIT_IRQ_MASK_OFS;
  localparam logic [7:0] FL = `WDIT_MODE_STAT_OFS;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wdit_bus_s bus = '0;
  wdit_pm_e pm = WDIT_PM_ACTIVE;
  logic ien = 1'b0;
  logic [7:0] rdata;
  logic flag;
  logic rreq;
  logic irq;
  int mismatches = 0;
  int checks = 0;
  int c;

  always #10 clk = ~clk;

  // Watchdog tick every 8 clocks keeps a 64-period interval at 512 clocks
  wdit_top #(.WDCLK_HZ(6250000)) wdit_top_i (
    .clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .power_mode(pm), .timer_interval_irq_enable(ien),
    .timer_interval_flag(flag), .system_reset_req(rreq), .irq(irq));

  // ==========================================================
  // Shared tasks
  task final_report;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task do_rst;
    @(posedge clk);
    sys_rst <= 1'b1;
    pm <= WDIT_PM_ACTIVE;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_rst

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd

  // Counts cycles until the flag (w=1) or reset request rises, at most n
  task wait_sig(input bit w, input int n, output int k);
    k = 0;
    @(negedge clk);
    while (k < n && (w ? flag : rreq) !== 1'b1) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_sig

  task key;
    wr(CT, 8'hAB);
    wr(CT, 8'h5B);
  endtask : key

  task set_pm(input wdit_pm_e m);
    @(posedge clk);
    pm <= m;
  endtask : set_pm

  // ==========================================================
  // Scenarios
  task t_timer;
    rd(CT, 8'h00);
    rd(8'h55, 8'h00);
    wr(CT, 8'h07);
    wr(CT, 8'hA7);
    rd(CT, 8'h07);
    wr(CT, 8'h0F);
    wait_sig(1'b1, 700, c);
    chk(8'(c inside {[495:540]}), 8'h01);
    chk({6'h00, rreq, irq}, 8'h00);
    wr(MK, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    rd(ST, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(ST, 8'h00);
    @(posedge clk);
    ien <= 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(FL, 8'h01);
    repeat (2) @(negedge clk);
    chk({6'h00, flag, irq}, 8'h00);
    // Clear bit 0 in timer mode restarts the interval
    repeat (300) @(posedge clk);
    wr(CT, 8'h1F);
    wait_sig(1'b1, 700, c);
    chk(8'(c inside {[495:540]}), 8'h01);
    wr(FL, 8'h01);
    wr(CT, 8'h07);
    wait_sig(1'b1, 700, c);
    chk(8'(c == 700), 8'h01);
    wr(CT, 8'h0E);
    wait_sig(1'b1, 4200, c);
    chk(8'(c inside {[4080:4120]}), 8'h01);
  endtask : t_timer

  task t_wdog;
    int n;
    do_rst();
    wr(CT, 8'h0B);
    wr(CT, 8'h07);
    rd(CT, 8'h0B);
    for (int i = 0; i < 3; i++) begin
      wait_sig(1'b0, 300, c);
      chk(8'(c == 300), 8'h01);
      key();
    end
    wait_sig(1'b0, 300, c);
    // Keys too far apart must not clear
    wr(CT, 8'hAB);
    repeat (20) @(posedge clk);
    wr(CT, 8'h5B);
    wait_sig(1'b0, 300, c);
    chk(8'(c < 240), 8'h01);
    n = 0;
    while (rreq === 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'h04);
    rd(ST, 8'h02);
    do_rst();
    rd(CT, 8'h00);
  endtask : t_wdog

  task t_power;
    wr(CT, 8'h0B);
    set_pm(WDIT_PM_LIGHT);
    wait_sig(1'b0, 700, c);
    chk(8'(c == 700), 8'h01);
    set_pm(WDIT_PM_ACTIVE);
    wait_sig(1'b0, 10, c);
    chk(8'(c < 10), 8'h01);
    do_rst();
    wr(CT, 8'h0B);
    repeat (400) @(posedge clk);
    set_pm(WDIT_PM_DEEP);
    wait_sig(1'b0, 1000, c);
    chk(8'(c == 1000), 8'h01);
    rd(CT, 8'h0B);
    set_pm(WDIT_PM_ACTIVE);
    wait_sig(1'b0, 600, c);
    chk(8'(c inside {[495:540]}), 8'h01);
    // Clears in light sleep keep the wake quiet; idle still resets
    do_rst();
    wr(CT, 8'h0B);
    set_pm(WDIT_PM_LIGHT);
    repeat (2) begin
      repeat (300) @(posedge clk);
      key();
    end
    set_pm(WDIT_PM_IDLE);
    wait_sig(1'b0, 200, c);
    chk(8'(c == 200), 8'h01);
    wait_sig(1'b0, 600, c);
    chk(8'(c inside {[250:400]}), 8'h01);
  endtask : t_power

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    do_rst();
    t_timer();
    t_wdog();
    t_power();
    final_report();
  end

  // Tests need about 12000 clocks; more than twice that means a hang
  initial begin
    #(20 * 30000);
    mismatches++;
    final_report();
  end
endmodule : wdit_top_test
